// File: tw_bus_asserts.sv
// Checker for the two-wire bus between master and memory target.
// Assumes link_clk oversamples scl and sda; sits beside tw_if.
`timescale 1ns/1ps
module tw_bus_asserts
  import tw_pkg::*;
#(
  parameter int WR_CYCLES_P = tw_pkg::WR_CYCLES
) (
  input wire logic link_clk, // Device clock
  input wire logic rst_n, // Device reset, active low
  input wire logic scl, // Bus clock
  input wire logic host_sda_oen, // Master pull enable
  input wire logic dev_sda_oen, // Target pull enable
  input wire logic sda // Resolved data line
);
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic framed_q = 1'b0;
  logic rd_q = 1'b0;
  logic [3:0] cnt_q = 4'h0;
  logic [7:0] sh_q = 8'h00;
  logic [1:0] words_q = 2'h0;
  int busy_q = 0;
  wire start_w = scl & scl_q & sda_q & ~sda;
  wire stop_w = scl & scl_q & ~sda_q & sda;
  wire rise_w = scl & ~scl_q;
  // ----------------------------------------------------------------
  // Bus framing tracker
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk) begin
    scl_q <= scl;
    sda_q <= sda;
  end
  always_ff @(posedge link_clk) begin
    if (!rst_n || start_w || stop_w) begin
      cnt_q <= 4'h0;
      framed_q <= start_w & rst_n;
      words_q <= 2'h0;
      rd_q <= 1'b0;
    end else if (rise_w) begin
      cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
      sh_q <= {sh_q[6:0], sda};
      if (cnt_q == 4'h7 && words_q == 2'h0) rd_q <= sda;
      if (cnt_q == 4'h8 && !sda && words_q != 2'h3) words_q <= words_q + 2'h1;
    end
  end
  // Write interval, trimmed for detection lag
  always_ff @(posedge link_clk) begin
    if (!rst_n) busy_q <= 0;
    else if (stop_w && framed_q && !rd_q && words_q >= 2'h2 && busy_q == 0)
      busy_q <= WR_CYCLES_P - 8;
    else if (busy_q != 0) busy_q <= busy_q - 1;
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge link_clk); endclocking
  default disable iff (!rst_n);
  property p_move_low;
    $changed(dev_sda_oen) |-> !scl;
  endproperty
  property p_idle_quiet;
    !framed_q |-> dev_sda_oen;
  endproperty
  property p_addr_quiet;
    framed_q && words_q == 2'h0 && cnt_q < 4'h8 |-> dev_sda_oen;
  endproperty
  property p_addr_match;
    rise_w && cnt_q == 4'h8 && words_q == 2'h0 && !dev_sda_oen
      |-> sh_q[7:4] == DEV_TYPE;
  endproperty
  property p_ack_window;
    framed_q && !rd_q && !dev_sda_oen |-> cnt_q == 4'h8 || cnt_q == 4'h0;
  endproperty
  property p_ack_release;
    framed_q && !rd_q && !dev_sda_oen && cnt_q == 4'h0 && !scl
      |-> ##[1:6] dev_sda_oen;
  endproperty
  property p_busy_silent;
    busy_q != 0 |-> dev_sda_oen;
  endproperty
  property p_rd_after_fall;
    framed_q && rd_q && $changed(dev_sda_oen) |-> $past(scl, 8);
  endproperty
  a_move_low: assert property (p_move_low)
    else $error("target moved data while clock high");
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("target pulled data outside a transfer");
  a_addr_quiet: assert property (p_addr_quiet)
    else $error("target pulled data during address bits");
  a_addr_match: assert property (p_addr_match)
    else $error("target acked a foreign address");
  a_ack_window: assert property (p_ack_window)
    else $error("target pulled data outside the ack slot");
  a_ack_release: assert property (p_ack_release)
    else $error("target held ack past the ninth clock");
  a_busy_silent: assert property (p_busy_silent)
    else $error("target answered during write interval");
  a_rd_after_fall: assert property (p_rd_after_fall)
    else $error("read data not moved just after clock fall");
  c_start: cover property (start_w);
  c_addr_ack: cover property (rise_w && cnt_q == 4'h8 && !dev_sda_oen);
  c_busy: cover property (busy_q == 1);
  c_read_stop: cover property (stop_w && rd_q);
endmodule

// File: tw_dev.sv
// Memory target end: start/stop detection, framing, ack, write interval.
// Assumes link_clk far faster than SCL; pins are oversampled.
// Overview of operation
// R1: Data moves only while clock is low
// R2: Start condition begins transfer at first bit
// R3: Rising data with clock high stops
// R4: Stop after read returns to standby
// R5: Standby at reset and after pending work
// R6: Eight bits MSB first, ack on ninth
// R7: Master recovers with nine clocks then start; master here starts as soon as data reads high, after at most nine clocks
// R8: Nonvolatile write ends within five milliseconds
// R9: Data line only pulled low or released
// R10: Address nibble 1010, low bit selects read
// R11: No ack while nonvolatile write runs
// R12: Start or stop mid-word resets bit count
`timescale 1ns/1ps
module tw_dev
  import tw_pkg::*;
#(
  parameter int WR_CYCLES_P = tw_pkg::WR_CYCLES
) (
  input wire logic link_clk, // Device clock
  input wire logic rst_n, // Sync reset, active low
  tw_if.dev bus, // Two-wire bus
  input wire logic [2:0] chip_select_straps, // Address straps
  input wire logic [7:0] rd_data, // Byte to send next
  output logic rd_next, // Pulse: rd_data taken
  output logic [7:0] wr_data, // Received data byte
  output logic wr_valid, // Pulse: wr_data new
  output logic nv_busy, // Write interval active
  output logic standby // Low-power standby
);
  import tw_pkg::*;

  localparam int TW = $clog2(WR_CYCLES_P + 1);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic scl_s1, scl_s2, scl_s3;
  logic sda_s1, sda_s2, sda_s3;
  logic [2:0] strap_s1, strap_s2;

  always_ff @(posedge link_clk) begin
    if (!rst_n) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
      strap_s1 <= 3'h0;
      strap_s2 <= 3'h0;
    end else begin
      scl_s1 <= bus.scl;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= bus.sda;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
      strap_s1 <= chip_select_straps;
      strap_s2 <= strap_s1;
    end
  end

  // ----------------------------------------------------------------
  // Bus condition decode
  // ----------------------------------------------------------------
  // R1: clock-high edges are conditions
  wire scl_high = scl_s2 & scl_s3;
  wire scl_rise = scl_s2 & ~scl_s3;
  wire scl_fall = ~scl_s2 & scl_s3;
  // R2: falling data, clock high
  wire start_det = scl_high & sda_s3 & ~sda_s2;
  // R3: rising data, clock high
  wire stop_det = scl_high & ~sda_s3 & sda_s2;

  tw_dev_st_t st_q, st_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] rx_q, rx_d;
  logic [7:0] tx_q, tx_d;
  logic addr_ph_q, addr_ph_d;
  logic rw_q, rw_d;
  logic wrote_q, wrote_d;
  logic mack_q, mack_d;
  logic sda_oen_q, sda_oen_d;
  logic busy_q, busy_d;
  logic [TW-1:0] timer_q, timer_d;
  logic [7:0] wr_data_q, wr_data_d;
  logic wr_valid_q, wr_valid_d;
  logic rd_next_q, rd_next_d;
  logic standby_q;

  wire active = (st_q == TW_DEV_RX) | (st_q == TW_DEV_TX);
  wire shifting = bit_q < BIT_ACK;
  wire word_end = scl_fall & (bit_q == BIT_ACK);
  wire slot_end = scl_fall & (bit_q == BIT_DONE);
  wire tx_bit = scl_fall & (st_q == TW_DEV_TX) & (bit_q >= BIT_FIRST)
                & (bit_q <= BIT_LAST);
  // R10: fixed nibble and strap compare
  wire type_hit = rx_q[7:4] == DEV_TYPE;
  // R11: no address ack while busy
  wire addr_hit = type_hit & (rx_q[3:1] == strap_s2) & ~busy_q;
  wire timer_end = timer_q == TW'(WR_CYCLES_P - 1);
  wire send_byte = (rw_q & (st_q == TW_DEV_RX)) |
                   ((st_q == TW_DEV_TX) & mack_q);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    rx_d = rx_q;
    tx_d = tx_q;
    addr_ph_d = addr_ph_q;
    rw_d = rw_q;
    wrote_d = wrote_q;
    mack_d = mack_q;
    sda_oen_d = sda_oen_q;
    busy_d = busy_q;
    timer_d = timer_q;
    wr_data_d = wr_data_q;
    wr_valid_d = 1'b0;
    rd_next_d = 1'b0;
    // R8: self-timed write interval
    if (busy_q) begin
      timer_d = TW'(timer_q + 1'b1);
      if (timer_end) begin
        busy_d = 1'b0;
        timer_d = '0;
      end
    end
    if (stop_det) begin
      // R12: abandon partial word on stop
      st_d = TW_DEV_STANDBY;
      bit_d = 4'h0;
      sda_oen_d = 1'b1;
      wrote_d = 1'b0;
      // R8: stop after write data commits
      if (wrote_q && !busy_q) begin
        busy_d = 1'b1;
        timer_d = '0;
      end
    end else if (start_det) begin
      // R12: resync bit count on start
      st_d = TW_DEV_RX;
      bit_d = 4'h0;
      addr_ph_d = 1'b1;
      rw_d = 1'b0;
      wrote_d = 1'b0;
      sda_oen_d = 1'b1;
    end else if (active) begin
      if (scl_rise && shifting) begin
        // R6: shift in MSB first
        rx_d = {rx_q[6:0], sda_s2};
        bit_d = 4'(bit_q + 4'h1);
      end else if (scl_rise) begin
        mack_d = ~sda_s2;
        bit_d = BIT_DONE;
      end else if (tx_bit) begin
        tx_d = {tx_q[6:0], 1'b0};
        // R9: release for one, pull for zero
        sda_oen_d = tx_q[6];
      end else if (word_end) begin
        if (addr_ph_q) begin
          addr_ph_d = 1'b0;
          rw_d = rx_q[0];
          if (addr_hit) begin
            // R6: ack the address word
            sda_oen_d = 1'b0;
          end else begin
            st_d = TW_DEV_STANDBY;
          end
        end else if (st_q == TW_DEV_RX) begin
          // R6: ack each data word
          sda_oen_d = 1'b0;
          wr_data_d = rx_q;
          wr_valid_d = 1'b1;
          wrote_d = 1'b1;
        end else begin
          sda_oen_d = 1'b1;
        end
      end else if (slot_end) begin
        bit_d = 4'h0;
        sda_oen_d = 1'b1;
        if (send_byte) begin
          st_d = TW_DEV_TX;
          tx_d = rd_data;
          sda_oen_d = rd_data[7];
          rd_next_d = 1'b1;
        end else if (st_q == TW_DEV_TX) begin
          st_d = TW_DEV_IGNORE;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk) begin
    if (!rst_n) begin
      // R5: standby from reset
      st_q <= TW_DEV_STANDBY;
      bit_q <= 4'h0;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      addr_ph_q <= 1'b0;
      rw_q <= 1'b0;
      wrote_q <= 1'b0;
      mack_q <= 1'b0;
      sda_oen_q <= 1'b1;
      busy_q <= 1'b0;
      timer_q <= '0;
      wr_data_q <= 8'h00;
      wr_valid_q <= 1'b0;
      rd_next_q <= 1'b0;
      standby_q <= 1'b1;
    end else begin
      st_q <= st_d;
      bit_q <= bit_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      addr_ph_q <= addr_ph_d;
      rw_q <= rw_d;
      wrote_q <= wrote_d;
      mack_q <= mack_d;
      sda_oen_q <= sda_oen_d;
      busy_q <= busy_d;
      timer_q <= timer_d;
      wr_data_q <= wr_data_d;
      wr_valid_q <= wr_valid_d;
      rd_next_q <= rd_next_d;
      // R4: standby once idle and not writing
      standby_q <= (st_d == TW_DEV_STANDBY) & ~busy_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign bus.dev_sda_oen = sda_oen_q;
  assign rd_next = rd_next_q;
  assign wr_data = wr_data_q;
  assign wr_valid = wr_valid_q;
  assign nv_busy = busy_q;
  assign standby = standby_q;
endmodule

// File: tw_host.sv
// Bus master end: makes SCL by division, frames bytes, recovers bus.
// Assumes one command at a time from logic on ref_clk.
`timescale 1ns/1ps
module tw_host
  import tw_pkg::*;
#(
  parameter int QTR_P = tw_pkg::SCL_QTR
) (
  input wire logic ref_clk, // Host clock, 40 MHz
  input wire logic rst_n, // Sync reset, active low
  tw_if.host bus, // Two-wire bus
  input wire logic cmd_valid, // Command offered
  input wire tw_pkg::tw_cmd_t cmd, // Command kind
  input wire logic [7:0] cmd_data, // Byte to write
  input wire logic cmd_nack, // Read: answer no-ack
  output logic cmd_ready, // Idle, takes command
  output logic rsp_valid, // Pulse: command done
  output logic [7:0] rsp_data, // Byte read
  output logic rsp_ack // Ack seen or bus free
);
  import tw_pkg::*;

  logic sda_s1, sda_s2;
  tw_host_st_t st_q, st_d;
  logic [15:0] div_q, div_d;
  logic [1:0] ph_q, ph_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] rx_q, rx_d;
  logic rd_q, rd_d;
  logic nack_q, nack_d;
  logic scl_q, scl_d;
  logic oen_q, oen_d;
  logic ack_q, ack_d;
  logic done;

  wire tick = div_q == 16'(QTR_P - 1);
  wire in_byte = cnt_q < BIT_ACK;
  wire bit_out = rd_q ? 1'b1 : sh_q[7];

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    div_d = tick ? 16'h0000 : 16'(div_q + 16'h0001);
    ph_d = ph_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    rx_d = rx_q;
    rd_d = rd_q;
    nack_d = nack_q;
    scl_d = scl_q;
    oen_d = oen_q;
    ack_d = ack_q;
    done = 1'b0;
    if (st_q == TW_HS_IDLE) begin
      div_d = 16'h0000;
      ph_d = PH_DATA;
      cnt_d = 4'h0;
      if (cmd_valid) begin
        sh_d = cmd_data;
        rd_d = cmd == TW_CMD_READ;
        nack_d = cmd_nack;
        case (cmd)
          TW_CMD_START: st_d = TW_HS_START;
          TW_CMD_STOP: st_d = TW_HS_STOP;
          TW_CMD_RECOVER: st_d = TW_HS_RECOV;
          default: st_d = TW_HS_BIT;
        endcase
      end
    end else if (tick) begin
      ph_d = 2'(ph_q + 2'h1);
      case (st_q)
        TW_HS_START: begin
          // R2: data falls while clock high
          case (ph_q)
            PH_DATA: oen_d = 1'b1;
            PH_RISE: scl_d = 1'b1;
            PH_SAMPLE: oen_d = 1'b0;
            default: begin
              scl_d = 1'b0;
              done = 1'b1;
            end
          endcase
        end
        TW_HS_STOP: begin
          // R3: data rises while clock high
          case (ph_q)
            PH_DATA: oen_d = 1'b0;
            PH_RISE: scl_d = 1'b1;
            PH_SAMPLE: oen_d = 1'b1;
            default: done = 1'b1;
          endcase
        end
        TW_HS_BIT: begin
          case (ph_q)
            // R1: data set while clock low
            PH_DATA: oen_d = in_byte ? bit_out : (~rd_q | nack_q);
            PH_RISE: scl_d = 1'b1;
            PH_SAMPLE: begin
              if (in_byte) begin
                rx_d = {rx_q[6:0], sda_s2};
              end else begin
                ack_d = ~sda_s2;
              end
            end
            default: begin
              scl_d = 1'b0;
              sh_d = {sh_q[6:0], 1'b0};
              cnt_d = 4'(cnt_q + 4'h1);
              done = cnt_q == BIT_ACK;
            end
          endcase
        end
        TW_HS_RECOV: begin
          // R7: clock until data seen high or nine clocks done
          case (ph_q)
            PH_DATA: oen_d = 1'b1;
            PH_RISE: scl_d = 1'b1;
            PH_SAMPLE: begin
              if (sda_s2) begin
                // Clock is high and data free: pull data next quarter
                ack_d = 1'b1;
                st_d = TW_HS_START;
                ph_d = PH_SAMPLE;
              end
            end
            default: begin
              scl_d = 1'b0;
              cnt_d = 4'(cnt_q + 4'h1);
              if (cnt_q == 4'(RECOV_CLOCKS - 1)) begin
                ack_d = 1'b0;
                st_d = TW_HS_START;
                ph_d = PH_DATA;
              end
            end
          endcase
        end
        default: st_d = TW_HS_IDLE;
      endcase
      if (done) begin
        st_d = TW_HS_IDLE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      st_q <= TW_HS_IDLE;
      div_q <= 16'h0000;
      ph_q <= PH_DATA;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      rx_q <= 8'h00;
      rd_q <= 1'b0;
      nack_q <= 1'b0;
      scl_q <= 1'b1;
      oen_q <= 1'b1;
      ack_q <= 1'b0;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      rsp_ack <= 1'b0;
    end else begin
      sda_s1 <= bus.sda;
      sda_s2 <= sda_s1;
      st_q <= st_d;
      div_q <= div_d;
      ph_q <= ph_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      rx_q <= rx_d;
      rd_q <= rd_d;
      nack_q <= nack_d;
      scl_q <= scl_d;
      oen_q <= oen_d;
      ack_q <= ack_d;
      cmd_ready <= (st_d == TW_HS_IDLE) & ~(cmd_valid & cmd_ready);
      rsp_valid <= done;
      rsp_data <= rx_d;
      rsp_ack <= ack_d;
    end
  end

  assign bus.scl = scl_q;
  assign bus.host_sda_oen = oen_q;
endmodule

// File: tw_if.sv
// Two-wire bus wires between master and memory target.
// Assumes both ends only pull low; released lines read high.
`timescale 1ns/1ps
interface tw_if;
  logic scl;
  logic host_sda_oen;
  logic dev_sda_oen;
  logic sda;
  // Wired-AND with pull-up
  assign sda = host_sda_oen & dev_sda_oen;
  modport host (output scl, output host_sda_oen, input sda);
  modport dev (input scl, input sda, output dev_sda_oen);
endinterface

// File: tw_pkg.sv
// Shared constants and types for the two-wire memory bus ends.
// Assumes a 40 MHz host clock and a 64 ns device clock.
package tw_pkg;
  // ----------------------------------------------------------------
  // Clock rates and timing
  // ----------------------------------------------------------------
  localparam int REF_CLK_KHZ = 40000;
  localparam int LINK_PERIOD_NS = 64;
  localparam int WR_MAX_MS = 5;
  localparam int WR_CYCLES = WR_MAX_MS * 1000000 / LINK_PERIOD_NS;
  localparam int SCL_KHZ = 100;
  localparam int SCL_QTR = REF_CLK_KHZ / (4 * SCL_KHZ);
  localparam int RECOV_CLOCKS = 9;
  // ----------------------------------------------------------------
  // Framing
  // ----------------------------------------------------------------
  localparam logic [3:0] DEV_TYPE = 4'ha;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_DONE = 4'h9;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_FIRST = 4'h1;
  localparam logic [1:0] PH_DATA = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_SAMPLE = 2'h2;
  localparam logic [1:0] PH_FALL = 2'h3;
  // ----------------------------------------------------------------
  // State and command types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TW_DEV_STANDBY, TW_DEV_RX, TW_DEV_TX, TW_DEV_IGNORE
  } tw_dev_st_t;
  typedef enum logic [2:0] {
    TW_HS_IDLE, TW_HS_START, TW_HS_STOP, TW_HS_BIT, TW_HS_RECOV
  } tw_host_st_t;
  typedef enum logic [2:0] {
    TW_CMD_START, TW_CMD_STOP, TW_CMD_WRITE, TW_CMD_READ, TW_CMD_RECOVER
  } tw_cmd_t;
endpackage

// File: two_wire_eeprom_bus_conditions_tb.sv
// Testbench: master and memory target joined over tw_if.
// Assumes QTR_P of 24 and a shortened write interval.
`timescale 1ns/1ps
`define CHECK_EQ(got, exp) begin check_count++; if ((got) !== (exp)) begin \
  errors++; $display("ERROR %0t: got %h want %h", $time, got, exp); end end
module two_wire_eeprom_bus_conditions_tb;
  import tw_pkg::*;
  localparam int WR_CYC = 1000;
  localparam logic [2:0] STRAPS = 3'h5;
  localparam logic [7:0] ADDR_W = {DEV_TYPE, STRAPS, 1'b0};
  localparam logic [7:0] ADDR_R = {DEV_TYPE, STRAPS, 1'b1};
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  tw_cmd_t cmd = TW_CMD_START;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_nack = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic cmd_ready, rsp_valid, rsp_ack, rd_next, wr_valid, nv_busy, standby;
  logic [7:0] rsp_data, wr_data;
  logic [7:0] wr_got = 8'h00;
  int rd_cnt = 0;
  int errors = 0;
  int check_count = 0;
  tw_if tw_if_inst();
  tw_host #(.QTR_P(24)) tw_host_inst(.ref_clk(ref_clk), .rst_n(rst_n),
    .bus(tw_if_inst.host), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_data(cmd_data), .cmd_nack(cmd_nack), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack));
  tw_dev #(.WR_CYCLES_P(WR_CYC)) tw_dev_inst(.link_clk(link_clk),
    .rst_n(rst_n), .bus(tw_if_inst.dev), .chip_select_straps(STRAPS),
    .rd_data(rd_data), .rd_next(rd_next), .wr_data(wr_data),
    .wr_valid(wr_valid), .nv_busy(nv_busy), .standby(standby));
  tw_bus_asserts #(.WR_CYCLES_P(WR_CYC)) tw_bus_asserts_inst(
    .link_clk(link_clk), .rst_n(rst_n), .scl(tw_if_inst.scl),
    .host_sda_oen(tw_if_inst.host_sda_oen),
    .dev_sda_oen(tw_if_inst.dev_sda_oen), .sda(tw_if_inst.sda));
  // ----------------------------------------------------------------
  // Clocks and monitors
  // ----------------------------------------------------------------
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    #7;
    forever #32 link_clk = ~link_clk;
  end
  always @(posedge link_clk) begin
    if (wr_valid === 1'b1) wr_got <= wr_data;
    if (rd_next === 1'b1) rd_cnt <= rd_cnt + 1;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic do_cmd(input tw_cmd_t k, input logic [7:0] d,
                        input logic nk = 1'b0);
    int n;
    for (n = 0; n < 50 && cmd_ready !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
    end
    `CHECK_EQ(cmd_ready, 1'b1)
    cmd_valid = 1'b1;
    cmd = k;
    cmd_data = d;
    cmd_nack = nk;
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b0;
    for (n = 0; n < 5000 && rsp_valid !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
    end
    `CHECK_EQ(n < 5000, 1'b1)
  endtask
  task automatic wait_ref(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    `CHECK_EQ(standby, 1'b1)
    `CHECK_EQ(nv_busy, 1'b0)
    $display("t_reset done");
  endtask
  task automatic t_write_poll();
    int n;
    do_cmd(TW_CMD_START, 8'h00);
    do_cmd(TW_CMD_WRITE, ADDR_W);
    `CHECK_EQ(rsp_ack, 1'b1)
    do_cmd(TW_CMD_WRITE, 8'ha5);
    `CHECK_EQ(rsp_ack, 1'b1)
    `CHECK_EQ(wr_got, 8'ha5)
    do_cmd(TW_CMD_STOP, 8'h00);
    `CHECK_EQ(nv_busy, 1'b1)
    `CHECK_EQ(standby, 1'b0)
    do_cmd(TW_CMD_START, 8'h00);
    do_cmd(TW_CMD_WRITE, ADDR_W);
    `CHECK_EQ(rsp_ack, 1'b0)
    do_cmd(TW_CMD_STOP, 8'h00);
    for (n = 0; n < 4000 && nv_busy !== 1'b0; n++) wait_ref(1);
    `CHECK_EQ(n < 2600, 1'b1)
    wait_ref(4);
    `CHECK_EQ(standby, 1'b1)
    $display("t_write_poll done");
  endtask
  task automatic t_bad_addr();
    do_cmd(TW_CMD_START, 8'h00);
    do_cmd(TW_CMD_WRITE, {4'hb, STRAPS, 1'b0});
    `CHECK_EQ(rsp_ack, 1'b0)
    do_cmd(TW_CMD_START, 8'h00);
    do_cmd(TW_CMD_WRITE, {DEV_TYPE, 3'h2, 1'b0});
    `CHECK_EQ(rsp_ack, 1'b0)
    do_cmd(TW_CMD_STOP, 8'h00);
    wait_ref(4);
    `CHECK_EQ(nv_busy, 1'b0)
    `CHECK_EQ(standby, 1'b1)
    $display("t_bad_addr done");
  endtask
  task automatic t_read();
    rd_data = 8'h3c;
    do_cmd(TW_CMD_START, 8'h00);
    do_cmd(TW_CMD_WRITE, ADDR_R);
    `CHECK_EQ(rsp_ack, 1'b1)
    do_cmd(TW_CMD_READ, 8'h00);
    `CHECK_EQ(rsp_data, 8'h3c)
    // Next byte presented before the target loads it
    rd_data = 8'hc3;
    do_cmd(TW_CMD_READ, 8'h00, 1'b1);
    `CHECK_EQ(rsp_data, 8'hc3)
    `CHECK_EQ(rd_cnt == 2, 1'b1)
    do_cmd(TW_CMD_STOP, 8'h00);
    wait_ref(4);
    `CHECK_EQ(standby, 1'b1)
    `CHECK_EQ(nv_busy, 1'b0)
    $display("t_read done");
  endtask
  task automatic t_recover();
    do_cmd(TW_CMD_RECOVER, 8'h00);
    `CHECK_EQ(rsp_ack, 1'b1)
    do_cmd(TW_CMD_STOP, 8'h00);
    rd_data = 8'h00;
    do_cmd(TW_CMD_START, 8'h00);
    do_cmd(TW_CMD_WRITE, ADDR_R);
    `CHECK_EQ(rsp_ack, 1'b1)
    do_cmd(TW_CMD_RECOVER, 8'h00);
    `CHECK_EQ(rsp_ack, 1'b1)
    do_cmd(TW_CMD_WRITE, ADDR_W);
    `CHECK_EQ(rsp_ack, 1'b1)
    do_cmd(TW_CMD_STOP, 8'h00);
    wait_ref(4);
    `CHECK_EQ(nv_busy, 1'b0)
    $display("t_recover done");
  endtask
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge link_clk);
    @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    wait_ref(2);
    t_reset();
    t_write_poll();
    t_bad_addr();
    t_read();
    t_recover();
    complete_run();
  end
  initial begin
    #1000000;
    errors++;
    complete_run();
  end
endmodule
